// >>> src/nfh_pkg.sv
// Constants for the NAND flash host port controller.
// Assumes a 125 MHz CLOCK driving the flash pins directly.
// What the document requires of host and device
// RULE_01: Command byte is latched on write strobe rise while command latch high.
// RULE_02: Address byte is latched on write strobe rise while address latch high.
// RULE_03: Select high while ready puts the device into standby.
// RULE_04: Busy device ignores select; host keeps select low through busy.
// RULE_05: Each read strobe fall presents a byte and advances the column.
// RULE_06: Protect low blocks program and erase inside the device.
// RULE_07: Long read strobe high time lets the device release its outputs.
// RULE_08: Short high time keeps outputs driven until latch or select edge.
// RULE_09: Host programs one page at most four times before erase.
// RULE_10: Single page program ends within 700 us.
// RULE_11: Multi page program ends within 700 us.
// RULE_12: Busy after the 11h confirm lasts at most 1 us.
// RULE_13: Single page read transfer ends within 220 us.
// RULE_14: Multi page read transfer ends within 420 us.
// RULE_15: Reset ends within 5, 5, 10 or 500 us depending on activity.
// RULE_16: After ECC status command the host reads all eight sector bytes.
// RULE_17: ECC status command only after ready returns, before data output; the host issues it as its own operation from idle, after any read data.
// RULE_18: Host never drives the port while the device outputs data.
// RULE_19: Ready/busy stays low for the whole operation, high when done.
// RULE_20: Each address is five latch cycles: two column, three page bytes.
// RULE_21: While busy the host issues only status or reset, strobes high.
package nfh_pkg;
  localparam int CLK_MHZ = 125;
  // Pin timing in ns and derived cycle counts (least times round up)
  localparam int T_SETUP_NS = 12;
  localparam int T_STROBE_NS = 12;
  localparam int T_HOLD_NS = 10;
  localparam int T_WHR_NS = 60;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int WHR_CYC = (T_WHR_NS * CLK_MHZ + 999) / 1000;
  // Busy limits in us, converted to cycles
  localparam int T_PROG_MAX_US = 700;
  localparam int T_RESET_MAX_US = 500;
  localparam int BUSY_MAX_CYC = T_PROG_MAX_US * CLK_MHZ;
  localparam int RESET_MAX_CYC = T_RESET_MAX_US * CLK_MHZ;
  localparam int TIMER_W = 20;
  localparam int ADDR_CYCLES = 5;
  localparam int ECC_BYTES = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 16;
  // Command codes
  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ2 = 8'h30;
  localparam logic [7:0] CMD_PROG1 = 8'h80;
  localparam logic [7:0] CMD_PROG2 = 8'h10;
  localparam logic [7:0] CMD_MPROG = 8'h11;
  localparam logic [7:0] CMD_ERASE1 = 8'h60;
  localparam logic [7:0] CMD_ERASE2 = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_ECC = 8'h7A;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  // Host operation codes
  typedef enum logic [2:0] {
    OP_READ  = 3'h0,
    OP_PROG  = 3'h1,
    OP_MPROG = 3'h2,
    OP_ERASE = 3'h3,
    OP_RESET = 3'h4,
    OP_ECC   = 3'h5,
    OP_STAT  = 3'h6
  } nfh_op_t;
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_CMD1 = 8'h02,
    S_ADDR = 8'h04,
    S_WDAT = 8'h08,
    S_CMD2 = 8'h10,
    S_BUSY = 8'h20,
    S_RDAT = 8'h40,
    S_DONE = 8'h80
  } nfh_state_t;
endpackage

// >>> src/nfh_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module nfh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Full and empty come straight from the count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overflow: assert property (@(posedge clk) disable iff (rst)
    count <= (AW+1)'(DEPTH)) else $error("FIFO count above depth");
endmodule
`default_nettype wire

// >>> src/nfh_host.sv
// Host controller that sequences commands onto the NAND flash pins.
// Assumes the flash is wired directly; ready/busy has an external pull-up.
`timescale 1ns/1ps
`default_nettype none
module nfh_host
  import nfh_pkg::*;
(
  // Clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // Operation request
  input  wire logic       OP_VALID,
  output logic            OP_READY,
  input  wire logic [2:0] OP_CODE,
  input  wire logic [39:0] OP_ADDR,
  input  wire logic [15:0] OP_LEN,
  // Write data stream into the FIFO
  input  wire logic       WR_VALID,
  output logic            WR_READY,
  input  wire logic [7:0] WR_DATA,
  // Read data stream
  output logic            RD_VALID,
  output logic      [7:0] RD_DATA,
  output logic            OP_DONE,
  output logic            OP_TIMEOUT,
  // Flash pins
  output logic            CMD_LATCH,
  output logic            ADDR_LATCH,
  output logic            SELECT_N,
  output logic            WRITE_STROBE_N,
  output logic            READ_STROBE_N,
  output logic            PROTECT_N,
  input  wire logic [7:0] SHARED_BYTE_PORT_I,
  output logic      [7:0] SHARED_BYTE_PORT_O,
  output logic            SHARED_BYTE_PORT_OE,
  input  wire logic       READY_BUSY_N
);
  nfh_state_t state;
  nfh_op_t    op;
  logic [39:0] addr;
  logic [CNT_W-1:0] len;
  logic [CNT_W-1:0] idx;
  logic [2:0]  phase;
  logic [TIMER_W-1:0] timer;
  logic [2:0]  rb_sync;
  logic        rb_ready;
  logic        f_valid;
  logic        f_ready;
  logic [7:0]  f_data;
  logic        phase_end;

  // Write data buffer; back-pressure reaches the source via WR_READY
  nfh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (CLOCK),
    .rst      (RST),
    .in_valid (WR_VALID),
    .in_ready (WR_READY),
    .in_data  (WR_DATA),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data (f_data)
  );

  // Ready/busy is asynchronous: three stages, change when last two agree
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rb_sync  <= 3'h0;
      rb_ready <= 1'b0;
    end else begin
      rb_sync <= {rb_sync[1:0], READY_BUSY_N};
      if (rb_sync[1] == rb_sync[2]) rb_ready <= rb_sync[2];
    end
  end

  // One byte cycle: setup, strobe low, strobe high hold
  function automatic logic cycle_end(input logic [2:0] ph);
    return ph == 3'(SETUP_CYC + STROBE_CYC + HOLD_CYC - 1);
  endfunction
  assign phase_end = cycle_end(phase);
  // Data byte only taken when the FIFO has one; stall otherwise
  assign f_ready = (state == S_WDAT) && phase_end && f_valid;

  // Second command of a two-part operation
  function automatic logic [7:0] confirm(input nfh_op_t o);
    case (o)
      OP_READ:  return CMD_READ2;
      OP_PROG:  return CMD_PROG2;
      OP_MPROG: return CMD_MPROG;
      OP_ERASE: return CMD_ERASE2;
      default:  return CMD_READ2;
    endcase
  endfunction
  function automatic logic [7:0] first_cmd(input nfh_op_t o);
    case (o)
      OP_READ:  return CMD_READ1;
      OP_PROG, OP_MPROG: return CMD_PROG1;
      OP_ERASE: return CMD_ERASE1;
      OP_RESET: return CMD_RESET;
      OP_ECC:   return CMD_ECC;
      default:  return CMD_STATUS;
    endcase
  endfunction

  // Sequencer; strobes are timed by phase
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state <= S_IDLE;
      op <= OP_READ;
      addr <= '0;
      len <= '0;
      idx <= '0;
      phase <= '0;
      timer <= '0;
      OP_READY <= 1'b0;
      OP_DONE <= 1'b0;
      OP_TIMEOUT <= 1'b0;
      RD_VALID <= 1'b0;
      RD_DATA <= 8'h00;
      CMD_LATCH <= 1'b0;
      ADDR_LATCH <= 1'b0;
      SELECT_N <= 1'b1;
      WRITE_STROBE_N <= 1'b1;
      READ_STROBE_N <= 1'b1;
      PROTECT_N <= 1'b0; // see RULE_06
      SHARED_BYTE_PORT_O <= 8'h00;
      SHARED_BYTE_PORT_OE <= 1'b0;
    end else begin
      OP_DONE <= 1'b0;
      RD_VALID <= 1'b0;
      phase <= phase_end ? 3'h0 : phase + 3'h1;
      // Write strobe low in middle phases, rising at strobe end
      WRITE_STROBE_N <= !((state == S_CMD1 || state == S_ADDR ||
        state == S_CMD2 || (state == S_WDAT && f_valid)) &&
        phase >= 3'(SETUP_CYC) && phase < 3'(SETUP_CYC + STROBE_CYC));
      case (state)
        S_IDLE: begin
          OP_READY <= 1'b1;
          SELECT_N <= 1'b1; // see RULE_03
          SHARED_BYTE_PORT_OE <= 1'b0;
          phase <= '0;
          if (OP_VALID && OP_READY) begin
            OP_READY <= 1'b0;
            op <= nfh_op_t'(OP_CODE);
            addr <= OP_ADDR;
            len <= OP_LEN;
            OP_TIMEOUT <= 1'b0;
            PROTECT_N <= (OP_CODE == OP_PROG || OP_CODE == OP_MPROG ||
                          OP_CODE == OP_ERASE);
            SELECT_N <= 1'b0;
            state <= S_CMD1;
          end
        end
        S_CMD1: begin
          CMD_LATCH <= 1'b1; // see RULE_01
          SHARED_BYTE_PORT_OE <= 1'b1;
          SHARED_BYTE_PORT_O <= first_cmd(op);
          idx <= '0;
          if (phase_end) begin
            CMD_LATCH <= 1'b0;
            if (op == OP_RESET) begin
              SHARED_BYTE_PORT_OE <= 1'b0;
              timer <= '0;
              state <= S_BUSY;
            end else if (op == OP_ECC || op == OP_STAT) begin
              SHARED_BYTE_PORT_OE <= 1'b0; // see RULE_18
              len <= (op == OP_ECC) ? CNT_W'(ECC_BYTES) : CNT_W'(1); // see RULE_16
              phase <= '0;
              timer <= '0;
              state <= S_RDAT;
            end else begin
              state <= S_ADDR;
            end
          end
        end
        S_ADDR: begin
          ADDR_LATCH <= 1'b1; // see RULE_02
          // Read, program and erase, erase included, send all five address bytes; reset, ECC and status skip this state
          SHARED_BYTE_PORT_O <= addr[8*idx[2:0] +: 8]; // see RULE_20
          if (phase_end) begin
            idx <= idx + 1'b1;
            if (idx == CNT_W'(ADDR_CYCLES - 1)) begin
              ADDR_LATCH <= 1'b0;
              idx <= '0;
              state <= (op == OP_PROG || op == OP_MPROG) ? S_WDAT : S_CMD2;
            end
          end
        end
        S_WDAT: begin
          SHARED_BYTE_PORT_O <= f_data;
          if (!f_valid) phase <= '0; // Stall the strobe until data arrives
          if (f_ready) begin
            idx <= idx + 1'b1;
            if (idx == len - 1'b1) state <= S_CMD2;
          end
        end
        S_CMD2: begin
          CMD_LATCH <= 1'b1;
          SHARED_BYTE_PORT_O <= confirm(op);
          if (phase_end) begin
            CMD_LATCH <= 1'b0;
            SHARED_BYTE_PORT_OE <= 1'b0;
            timer <= '0;
            state <= S_BUSY;
          end
        end
        S_BUSY: begin
          // Strobes stay high and select low while busy
          timer <= timer + 1'b1; // see RULE_21
          // Short busy after 11h ends here as well; see RULE_12
          if (timer > TIMER_W'(WHR_CYC + 4) && rb_ready) begin // see RULE_19
            idx <= '0;
            phase <= '0;
            state <= (op == OP_READ) ? S_RDAT : S_DONE;
          end else if (timer == TIMER_W'(
              (op == OP_RESET ? RESET_MAX_CYC : BUSY_MAX_CYC))) begin
            OP_TIMEOUT <= 1'b1; // see RULE_10 RULE_11 RULE_13 RULE_14 RULE_15
            state <= S_DONE;
          end
        end
        S_RDAT: begin
          // First strobe fall waits out the write-to-read gap after a command
          timer <= timer + 1'b1;
          if (timer < TIMER_W'(WHR_CYC)) phase <= '0;
          // Strobe low in the middle phases
          READ_STROBE_N <= !(phase >= 3'(SETUP_CYC) &&
                            phase < 3'(SETUP_CYC + STROBE_CYC)); // see RULE_05
          // Byte taken while the strobe is still low: the device may
          // release its drivers as soon as the strobe rises
          if (phase == 3'(SETUP_CYC + STROBE_CYC - 1)) begin
            RD_DATA <= SHARED_BYTE_PORT_I; // see RULE_07 RULE_08
          end
          if (phase_end) begin
            RD_VALID <= 1'b1;
            idx <= idx + 1'b1;
            if (idx == len - 1'b1) state <= S_DONE;
          end
        end
        S_DONE: begin
          READ_STROBE_N <= 1'b1;
          PROTECT_N <= 1'b0;
          SELECT_N <= 1'b1;
          OP_DONE <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  a_busy_strobes_high: assert property (@(posedge CLOCK) disable iff (RST)
    state == S_BUSY |-> WRITE_STROBE_N && READ_STROBE_N) // see RULE_21
    else $error("Strobe active while busy");
  a_no_drive_on_read: assert property (@(posedge CLOCK) disable iff (RST)
    !READ_STROBE_N |-> !SHARED_BYTE_PORT_OE) // see RULE_18
    else $error("Port driven during read");
  a_select_held_busy: assert property (@(posedge CLOCK) disable iff (RST)
    state == S_BUSY |-> !SELECT_N) // see RULE_04
    else $error("Select dropped while busy");
  a_latch_exclusive: assert property (@(posedge CLOCK) disable iff (RST)
    !(CMD_LATCH && ADDR_LATCH)) // see RULE_01
    else $error("Both latches high");
  a_protect_idle: assert property (@(posedge CLOCK) disable iff (RST)
    state == S_IDLE && $past(state) == S_DONE |-> !PROTECT_N) // see RULE_06
    else $error("Protect left open after operation");
  a_idle_deselect: assert property (@(posedge CLOCK) disable iff (RST)
    state == S_DONE |=> SELECT_N) // see RULE_03
    else $error("Select not released after operation");
  a_ecc_after_ready: assert property (@(posedge CLOCK) disable iff (RST)
    CMD_LATCH && SHARED_BYTE_PORT_O == CMD_ECC |-> rb_ready) // see RULE_17
    else $error("ECC status issued while busy");
  a_done_pulse: assert property (@(posedge CLOCK) disable iff (RST)
    OP_DONE |=> !OP_DONE) // see RULE_19
    else $error("Done longer than one cycle");
endmodule
`default_nettype wire

// >>> verification/nfh_flash_model.sv
// Behavioural flash device on the far side of the host port.
// Assumes host-driven pins; a 16-byte page stands for the array.
`timescale 1ns/1ps
`default_nettype none
module nfh_flash_model #(
  parameter int BUSY_NS  = 2000,
  parameter int SHORT_NS = 400
) (
  // Control pins from the host
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       select_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       protect_n,
  // Shared byte port and ready/busy
  input  wire logic [7:0] bus_in,
  output logic      [7:0] bus_out,
  output logic            bus_oe,
  output logic            busy
);
  logic [7:0]  page [16];
  logic [7:0]  pend [16];
  logic [7:0]  last_cmd;
  logic [39:0] addr;
  logic [3:0]  col;
  logic        stat_mode;
  logic        ecc_mode;
  logic        standby;
  int          acnt;
  int          busy_len;
  event        go;

  // Known page content so that reads can be predicted
  initial begin
    for (int i = 0; i < 16; i++) page[i] = 8'hA5 ^ 8'(i);
    {bus_out, bus_oe, busy, stat_mode, ecc_mode, standby} = '0;
    acnt = 5;
    col = '0;
  end

  // Busy well inside the maxima, so a slow host still sees it end
  always @(go) begin
    busy = 1'b1;
    #(busy_len);
    busy = 1'b0;
  end

  // Commands, address bytes and data in, all on the write strobe rise
  always @(posedge write_strobe_n) begin
    if (!select_n && cmd_latch) begin
      last_cmd = bus_in;
      stat_mode = (bus_in == 8'h70);
      ecc_mode = (bus_in == 8'h7A);
      col = '0;
      busy_len = (bus_in inside {8'h30, 8'h10, 8'hD0}) ? BUSY_NS : SHORT_NS;
      if (bus_in inside {8'h00, 8'h80, 8'h60}) acnt = 0;
      if (bus_in == 8'h30) col = addr[3:0];
      // Protect low leaves the array untouched and the device ready, except that 11h still sets busy
      if (bus_in == 8'h10 && protect_n) page = pend;
      if (bus_in inside {8'h30, 8'h11, 8'hFF}) -> go;
      if (bus_in inside {8'h10, 8'hD0} && protect_n) -> go;
    end else if (!select_n && addr_latch && acnt < 5) begin
      addr[8*acnt +: 8] = bus_in;
      acnt++;
      col = addr[3:0];
    end else if (!select_n && !addr_latch) begin
      pend[col] = bus_in;
      col++;
    end
  end

  // Each read strobe fall shows the byte at the column, then steps it
  always @(negedge read_strobe_n) begin
    if (!select_n) begin
      bus_out = stat_mode ? {1'b1, ~busy, 6'h00} :
                ecc_mode ? 8'h10 + {4'h0, col} : page[col];
      bus_oe = 1'b1;
      col++;
    end
  end

  // Long strobe high time: drivers off at the rise and at latch edges
  always @(posedge read_strobe_n or posedge cmd_latch or posedge addr_latch
           or posedge select_n or negedge write_strobe_n)
    bus_oe = 1'b0;

  // Select rising only counts while ready
  always @(select_n) standby = select_n && !busy;
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the NAND flash host port controller.
// Assumes the behavioural flash model on the far side of the pins.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import nfh_pkg::*;
  logic        CLOCK = 1'b0;
  logic        RST = 1'b1;
  logic        OP_VALID = 1'b0;
  logic [2:0]  OP_CODE = '0;
  logic [39:0] OP_ADDR = '0;
  logic [15:0] OP_LEN = '0;
  logic        WR_VALID = 1'b0;
  logic [7:0]  WR_DATA = '0;
  logic        OP_READY, WR_READY, RD_VALID, OP_DONE, OP_TIMEOUT;
  logic [7:0]  RD_DATA, SHARED_BYTE_PORT_O, m_out;
  logic        CMD_LATCH, ADDR_LATCH, SELECT_N, WRITE_STROBE_N;
  logic        READ_STROBE_N, PROTECT_N, SHARED_BYTE_PORT_OE, m_oe, m_busy;
  wire  [7:0]  port;
  wire         READY_BUSY_N;
  logic [7:0]  last_v = '0;
  logic [7:0]  rx [$];
  int          errors = 0;
  int          num_checks = 0;

  always #4 CLOCK = ~CLOCK;
  // Undriven port flips every cycle so a stale byte never passes
  assign port = SHARED_BYTE_PORT_OE ? SHARED_BYTE_PORT_O :
                m_oe ? m_out : ~last_v;
  always @(posedge CLOCK) last_v <= port;
  assign READY_BUSY_N = ~m_busy; // Pull-up when released

  nfh_host uut (
    .CLOCK(CLOCK), .RST(RST), .OP_VALID(OP_VALID), .OP_READY(OP_READY),
    .OP_CODE(OP_CODE), .OP_ADDR(OP_ADDR), .OP_LEN(OP_LEN),
    .WR_VALID(WR_VALID), .WR_READY(WR_READY), .WR_DATA(WR_DATA),
    .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .OP_DONE(OP_DONE),
    .OP_TIMEOUT(OP_TIMEOUT), .CMD_LATCH(CMD_LATCH), .ADDR_LATCH(ADDR_LATCH),
    .SELECT_N(SELECT_N), .WRITE_STROBE_N(WRITE_STROBE_N),
    .READ_STROBE_N(READ_STROBE_N), .PROTECT_N(PROTECT_N),
    .SHARED_BYTE_PORT_I(port), .SHARED_BYTE_PORT_O(SHARED_BYTE_PORT_O),
    .SHARED_BYTE_PORT_OE(SHARED_BYTE_PORT_OE), .READY_BUSY_N(READY_BUSY_N)
  );

  nfh_flash_model dev (
    .cmd_latch(CMD_LATCH), .addr_latch(ADDR_LATCH), .select_n(SELECT_N),
    .write_strobe_n(WRITE_STROBE_N), .read_strobe_n(READ_STROBE_N),
    .protect_n(PROTECT_N), .bus_in(port), .bus_out(m_out), .bus_oe(m_oe),
    .busy(m_busy)
  );

  task automatic check(input string what, input logic [39:0] exp,
                       input logic [39:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Pins watched every cycle: no clash on the port, strobes idle in busy
  always @(negedge CLOCK) begin
    if (m_oe) check("host drive", 40'h0, SHARED_BYTE_PORT_OE);
    if (m_busy) check("busy strobes", 40'h3, {READ_STROBE_N, WRITE_STROBE_N});
  end

  // One operation, gathering read bytes until done
  task automatic run_op(input nfh_op_t code, input logic [39:0] a,
                        input logic [15:0] n);
    int t;
    rx.delete();
    @(negedge CLOCK);
    OP_VALID = 1'b1;
    OP_CODE = code;
    OP_ADDR = a;
    OP_LEN = n;
    t = 0;
    while (!OP_READY && t < 100) begin
      @(negedge CLOCK);
      t++;
    end
    @(negedge CLOCK);
    OP_VALID = 1'b0;
    t = 0;
    while (!OP_DONE && t < 20000) begin
      if (RD_VALID) rx.push_back(RD_DATA);
      @(negedge CLOCK);
      t++;
    end
    check("op done", 40'h1, {39'h0, OP_DONE});
    check("no timeout", 40'h0, {39'h0, OP_TIMEOUT});
    check("ready at done", 40'h1, {39'h0, READY_BUSY_N});
  endtask

  // Hold valid until the FIFO takes the byte
  task automatic push(input logic [7:0] d);
    int t;
    WR_VALID = 1'b1;
    WR_DATA = d;
    t = 0;
    while (!WR_READY && t < 100) begin
      @(negedge CLOCK);
      t++;
    end
    @(negedge CLOCK);
  endtask

  // Read four bytes from column 4 of a five-byte address
  task automatic t_read();
    run_op(OP_READ, 40'h01_2345_0004, 16'd4);
    check("read cmd", 40'h30, dev.last_cmd);
    check("address", 40'h01_2345_0004, dev.addr);
    check("read count", 40'd4, 40'(rx.size()));
    foreach (rx[i]) check("read byte", 8'hA5 ^ 8'(4 + i), rx[i]);
  endtask

  // ECC status straight after the read, then a status byte
  task automatic t_ecc();
    run_op(OP_ECC, '0, 16'd8);
    check("ecc cmd", 40'h7A, dev.last_cmd);
    check("ecc count", 40'd8, 40'(rx.size()));
    foreach (rx[i]) check("ecc byte", 8'h10 + 8'(i), rx[i]);
    run_op(OP_STAT, '0, 16'd1);
    check("status", 40'hC0, rx[0]);
  endtask

  // Fill the FIFO until it refuses, program, then read the page back
  task automatic t_prog();
    @(negedge CLOCK);
    for (int i = 0; i < 16; i++) push(8'h30 + 8'(i));
    WR_VALID = 1'b0;
    check("fifo full", 40'h0, WR_READY);
    run_op(OP_PROG, '0, 16'd16);
    check("prog cmd", 40'h10, dev.last_cmd);
    for (int i = 0; i < 16; i++) check("page", 8'h30 + 8'(i), dev.page[i]);
    check("fifo drained", 40'h1, WR_READY);
    run_op(OP_READ, '0, 16'd16);
    foreach (rx[i]) check("read back", 8'h30 + 8'(i), rx[i]);
  endtask

  // Multi-page program, erase and reset, each ending in its command
  task automatic t_cmds();
    nfh_op_t    ops [3] = '{OP_MPROG, OP_ERASE, OP_RESET};
    logic [7:0] cmds [3] = '{8'h11, 8'hD0, 8'hFF};
    @(negedge CLOCK);
    push(8'h5A);
    WR_VALID = 1'b0;
    foreach (ops[i]) begin
      run_op(ops[i], 40'h00_0001_0000, 16'd1);
      check("final cmd", cmds[i], dev.last_cmd);
    end
  endtask

  initial begin
    repeat (8) @(posedge CLOCK);
    @(negedge CLOCK);
    RST = 1'b0;
    check("protect in reset", 40'h0, PROTECT_N);
    check("select in reset", 40'h1, SELECT_N);
    t_read();
    t_ecc();
    t_prog();
    t_cmds();
    conclude();
  end

  // Cut a hang short well past the expected run length
  initial begin
    #400000;
    errors++;
    conclude();
  end
endmodule
`default_nettype wire
